// >>> src/frame_timestamp.sv
// dual-port frame timestamp unit: tick counter, frame-sync reference,
// per-port capture at a target line or at frame start, snapshot hold.
// assumes line and frame start events arrive as one-cycle pulses
// synchronous to clk, and frame_sync is already synchronous to clk.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Function
// - frame sync edge is rising when edge select is 0, falling when 1
// - early ready mode flags ready once all enabled ports are captured
// - free run select 0 follows frame sync, 1 runs freely
// - capture point 0 captures at target line, 1 at frame start
// - snapshot hold freezes captured stamps and clears the ready flag
// - each port captures only while its enable bit is set
// - target line is upper and lower bytes; capture when that line starts
// - frame start with free run arms on reaching the target line
// - read-only ready flag shows stamps are available to read
// - read-only valid flag per port, bit 0 port 0, bit 1 port 1
// - port 0 stamp readable as upper and lower byte registers
// - port 1 stamp bytes sit right after the port 0 pair
module frame_timestamp (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       frame_sync,
  input  wire logic [1:0] line_start,
  input  wire logic [1:0] frame_start
);

  // ************************************************************
  // overview
  // ************************************************************
  // everything runs on clk and on the released copy of the reset.
  // the register port answers every read one cycle later and never
  // stalls, so a stamp is read one byte at a time; software that needs
  // both bytes of one capture sets the snapshot hold first.
  // the counter restarts on the chosen frame sync edge unless free run
  // is selected; in free run it only wraps, and the wrap closes the
  // reference period instead of the sync edge.
  // captures are per port; ready is shared by both ports.

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // the raw reset only asserts; release waits two edges so that no
  // flop leaves reset on a different edge than its neighbours
  wire rst_sync_n = rst_sync_q;

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] config_q;
  logic [7:0] control_q;
  logic [7:0] line_upper_q;
  logic [7:0] line_lower_q;

  // reserved bits are masked on the way in, so a readback never shows
  // a bit that the logic does not act on
  wire wr_config = reg_wr && (reg_addr == ts_pkg::OFF_CONFIG);
  wire wr_control = reg_wr && (reg_addr == ts_pkg::OFF_CONTROL);
  wire wr_upper = reg_wr && (reg_addr == ts_pkg::OFF_LINE_UPPER);
  wire wr_lower = reg_wr && (reg_addr == ts_pkg::OFF_LINE_LOWER);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      config_q     <= ts_pkg::CONFIG_RST;
      control_q    <= ts_pkg::CONTROL_RST;
      line_upper_q <= ts_pkg::LINE_RST;
      line_lower_q <= ts_pkg::LINE_RST;
    end else begin
      if (wr_config) begin
        config_q <= reg_wdata & ts_pkg::CFG_WMASK;
      end
      if (wr_control) begin
        control_q <= reg_wdata & ts_pkg::CTL_WMASK;
      end
      if (wr_upper) begin
        line_upper_q <= reg_wdata;
      end
      if (wr_lower) begin
        line_lower_q <= reg_wdata;
      end
    end
  end

  wire       edge_select   = config_q[ts_pkg::CFG_EDGE_BIT];
  wire [1:0] tick_select   = config_q[ts_pkg::CFG_RES_LSB +: 2];
  wire       early_ready   = config_q[ts_pkg::CFG_EARLY_BIT];
  wire       free_run      = config_q[ts_pkg::CFG_FREE_BIT];
  wire       frame_point   = config_q[ts_pkg::CFG_POINT_BIT];
  wire       snapshot_hold = control_q[ts_pkg::CTL_HOLD_BIT];
  wire [1:0] port_enable   = control_q[ts_pkg::CTL_EN_LSB +: 2];
  wire [15:0] target_line  = {line_upper_q, line_lower_q};

  // ************************************************************
  // frame sync reference
  // ************************************************************
  logic fs_prev_q;

  // the previous level resets to low, the idle level with rising edges
  // selected; a sync input already high at reset release gives one
  // early event, which only restarts the counter
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fs_prev_q <= 1'b0;
    end else begin
      fs_prev_q <= frame_sync;
    end
  end

  wire fs_rise = frame_sync && !fs_prev_q;
  wire fs_fall = !frame_sync && fs_prev_q;
  wire fs_event = edge_select ? fs_fall : fs_rise;

  // ************************************************************
  // tick prescaler and stamp counter
  // ************************************************************
  logic [6:0]  presc_q;
  logic [15:0] stamp_cnt_q;

  // terminal counts of the four resolutions; the slowest one still
  // fits the 7-bit prescaler at the device clock
  wire [6:0] cyc_res0 = 7'(ts_pkg::TICK0_CYC);
  wire [6:0] cyc_res1 = 7'(ts_pkg::TICK1_CYC);
  wire [6:0] cyc_res2 = 7'(ts_pkg::TICK2_CYC);
  wire [6:0] cyc_res3 = 7'(ts_pkg::TICK3_CYC);

  // period of the selected tick, in clock cycles
  wire [6:0] tick_cycles =
    (tick_select == 2'b00) ? cyc_res0 :
    (tick_select == 2'b01) ? cyc_res1 :
    (tick_select == 2'b10) ? cyc_res2 :
                             cyc_res3;

  // the prescaler compares with >= so a resolution change mid-period
  // never strands the count above the new terminal value
  wire tick = (presc_q >= tick_cycles - 7'h01);
  wire cnt_wrap = tick && (stamp_cnt_q == 16'hffff);
  wire ref_event = free_run ? cnt_wrap : fs_event;
  wire restart = !free_run && fs_event;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      presc_q     <= 7'h00;
      stamp_cnt_q <= ts_pkg::STAMP_RST;
    end else if (restart) begin
      presc_q     <= 7'h00;
      stamp_cnt_q <= ts_pkg::STAMP_RST;
    end else if (tick) begin
      presc_q     <= 7'h00;
      stamp_cnt_q <= stamp_cnt_q + 16'h0001;
    end else begin
      presc_q     <= presc_q + 7'h01;
    end
  end

  // ************************************************************
  // per-port capture
  // ************************************************************
  // each port keeps its own stamp and valid flop; the shared views
  // below are nets so that every flop has exactly one writer
  wire [15:0] stamp_hold [2];
  wire [1:0]  stamp_valid;
  wire [1:0]  capture;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic [15:0] line_cnt_q;
      logic        armed_q;
      logic [15:0] stamp_q;
      logic        valid_q;

      // a frame start clears the count, so the first line of a frame
      // is line 1; a frame start beside a line start wins
      wire [15:0] next_line = line_cnt_q + 16'h0001;
      wire        hit_line  = line_start[p] && (next_line == target_line);
      // with free run at frame start, only the first frame start after
      // reset or one seen after the target line of the previous frame is
      // taken; a frame with fewer lines than the target leaves the port disarmed
      wire        need_arm  = frame_point && free_run;
      wire        cap_frame = frame_start[p] && (armed_q || !need_arm);
      wire        cap_point = frame_point ? cap_frame : hit_line;
      wire        cap_gate  = port_enable[p] && !snapshot_hold;
      assign capture[p] = cap_point && cap_gate;

      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          line_cnt_q <= 16'h0000;
          armed_q    <= 1'b1;
        end else begin
          if (frame_start[p]) begin
            line_cnt_q <= 16'h0000;
          end else if (line_start[p]) begin
            line_cnt_q <= next_line;
          end
          if (capture[p]) begin
            armed_q <= 1'b0;
          end else if (hit_line) begin
            armed_q <= 1'b1;
          end
        end
      end

      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          stamp_q <= ts_pkg::STAMP_RST;
          valid_q <= 1'b0;
        end else if (capture[p]) begin
          stamp_q <= stamp_cnt_q;
          valid_q <= 1'b1;
        end
      end

      assign stamp_hold[p]  = stamp_q;
      assign stamp_valid[p] = valid_q;
    end
  endgenerate

  // ************************************************************
  // ready tracking
  // ************************************************************
  logic [1:0] got_q;
  logic       ready_q;

  // ports captured in the current reference period, counting this
  // cycle's captures so none is lost to the period boundary
  wire [1:0] got_now    = got_q | capture;
  wire       any_on     = (port_enable != 2'b00);
  wire [1:0] got_on     = got_now & port_enable;
  wire       all_done   = any_on && (got_on == port_enable);
  // normal ready waits for the event that closes the period; in free
  // run that event is the counter wrap, which may be far away
  wire       ready_norm = ref_event && all_done;
  wire       ready_set  = early_ready ? all_done : ready_norm;
  wire       early_end  = early_ready && all_done;
  wire       period_end = ref_event || early_end;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      got_q   <= 2'b00;
      ready_q <= 1'b0;
    end else begin
      got_q <= period_end ? 2'b00 : got_now;
      if (snapshot_hold) begin
        ready_q <= 1'b0;
      end else if (ready_set) begin
        ready_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // reserved status bits read as zero
  wire [7:0] state_byte = {3'b000, ready_q, 2'b00, stamp_valid};

  wire sel_config   = (reg_addr == ts_pkg::OFF_CONFIG);
  wire sel_control  = (reg_addr == ts_pkg::OFF_CONTROL);
  wire sel_upper    = (reg_addr == ts_pkg::OFF_LINE_UPPER);
  wire sel_lower    = (reg_addr == ts_pkg::OFF_LINE_LOWER);
  wire sel_state    = (reg_addr == ts_pkg::OFF_STATE);
  wire sel_p0_upper = (reg_addr == ts_pkg::OFF_P0_UPPER);
  wire sel_p0_lower = (reg_addr == ts_pkg::OFF_P0_LOWER);
  wire sel_p1_upper = (reg_addr == ts_pkg::OFF_P1_UPPER);
  wire sel_p1_lower = (reg_addr == ts_pkg::OFF_P1_LOWER);

  // no byte latch: the two halves of a stamp may come from different
  // captures unless the snapshot hold is set while they are read
  wire [7:0] rd_mux =
    sel_config   ? config_q :
    sel_control  ? control_q :
    sel_upper    ? line_upper_q :
    sel_lower    ? line_lower_q :
    sel_state    ? state_byte :
    sel_p0_upper ? stamp_hold[0][15:8] :
    sel_p0_lower ? stamp_hold[0][7:0] :
    sel_p1_upper ? stamp_hold[1][15:8] :
    sel_p1_lower ? stamp_hold[1][7:0] :
                   8'h00;

  // the read data return to zero outside a read, so a stale byte is
  // never taken for a fresh one
  logic [7:0] rdata_q;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ************************************************************
  // limitations
  // ************************************************************
  // valid bits clear only at reset; software tells a new capture from
  // an old one by the stamp value or by the ready flag.
  // a target line of 0 never matches, and 1 matches the first line of
  // a frame, which software is told to avoid.
  // line and frame start pulses are taken as one cycle long; a longer
  // line pulse counts one line per cycle.
  // a resolution change takes effect at once; the tick in flight ends at
  // the new period, or on the next cycle if it is already past it.

endmodule

`default_nettype wire

// >>> src/ts_pkg.sv
// timestamp unit package: register map, field layout, reset values
// and tick timing for the dual-port frame timestamp block.
// assumes a 125 MHz device clock and an 8-bit register port.
package ts_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFF_CONFIG     = 8'h25;
  localparam logic [7:0] OFF_CONTROL    = 8'h26;
  localparam logic [7:0] OFF_LINE_UPPER = 8'h27;
  localparam logic [7:0] OFF_LINE_LOWER = 8'h28;
  localparam logic [7:0] OFF_STATE      = 8'h29;
  localparam logic [7:0] OFF_P0_UPPER   = 8'h2a;
  localparam logic [7:0] OFF_P0_LOWER   = 8'h2b;
  localparam logic [7:0] OFF_P1_UPPER   = 8'h2c;
  localparam logic [7:0] OFF_P1_LOWER   = 8'h2d;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CFG_EDGE_BIT   = 6;
  localparam int CFG_RES_LSB    = 4;
  localparam int CFG_EARLY_BIT  = 3;
  localparam int CFG_FREE_BIT   = 1;
  localparam int CFG_POINT_BIT  = 0;
  localparam int CTL_HOLD_BIT   = 4;
  localparam int CTL_EN_LSB     = 0;
  localparam int ST_READY_BIT   = 4;
  localparam int ST_VALID_LSB   = 0;

  // writable bits; reserved bits are stored as zero
  localparam logic [7:0] CFG_WMASK = 8'h7b;
  localparam logic [7:0] CTL_WMASK = 8'h13;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] CONFIG_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] LINE_RST    = 8'h00;
  localparam logic [15:0] STAMP_RST  = 16'h0000;

  // ************************************************************
  // tick timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK0_NS      = 40;
  localparam int TICK1_NS      = 80;
  localparam int TICK2_NS      = 160;
  localparam int TICK3_US      = 1;
  localparam int TICK0_CYC = (TICK0_NS * 1000) / CLK_PERIOD_PS;
  localparam int TICK1_CYC = (TICK1_NS * 1000) / CLK_PERIOD_PS;
  localparam int TICK2_CYC = (TICK2_NS * 1000) / CLK_PERIOD_PS;
  localparam int TICK3_CYC = (TICK3_US * 1000000) / CLK_PERIOD_PS;

endpackage

// >>> verif/ts_properties.sv
// assertions on the timestamp unit register port
// sees only the top ports of frame_timestamp; bound at the foot
`timescale 1ns/1ps
`default_nettype none
module ts_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       frame_sync,
  input wire logic [1:0] line_start,
  input wire logic [1:0] frame_start
);
  logic [7:0] cfg_q, ctl_q, lnl_q;
  logic       v1_q;
  wire        rd_st = reg_rd && reg_addr == ts_pkg::OFF_STATE;
  wire        rd_cf = reg_rd && reg_addr == ts_pkg::OFF_CONFIG;
  wire        rd_ct = reg_rd && reg_addr == ts_pkg::OFF_CONTROL;
  wire        rd_ln = reg_rd && reg_addr == ts_pkg::OFF_LINE_LOWER;
  wire        off = reg_addr < 8'h25 || reg_addr > 8'h2d;
  // shadows follow the writes, so readback needs no help from the bench
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 8'h00;
      ctl_q <= 8'h00;
      lnl_q <= 8'h00;
      v1_q  <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ts_pkg::OFF_CONFIG)
        cfg_q <= reg_wdata & ts_pkg::CFG_WMASK;
      if (reg_wr && reg_addr == ts_pkg::OFF_CONTROL)
        ctl_q <= reg_wdata & ts_pkg::CTL_WMASK;
      if (reg_wr && reg_addr == ts_pkg::OFF_LINE_LOWER)
        lnl_q <= reg_wdata;
      if ($past(rd_st) && reg_rdata[1])
        v1_q <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("data outside read");
  property p_unmap; reg_rd && off |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_cfg; rd_cf |=> reg_rdata == $past(cfg_q); endproperty
  a_cfg: assert property (p_cfg) else $error("config readback");
  property p_ctl; rd_ct |=> reg_rdata == $past(ctl_q); endproperty
  a_ctl: assert property (p_ctl) else $error("control readback");
  property p_line; rd_ln |=> reg_rdata == $past(lnl_q); endproperty
  a_line: assert property (p_line) else $error("line readback");
  property p_hold; ctl_q[4] [*2] ##0 rd_st |=> !reg_rdata[4]; endproperty
  a_hold: assert property (p_hold) else $error("ready under hold");
  property p_resv; rd_st |=> (reg_rdata & 8'hec) == 8'h00; endproperty
  a_resv: assert property (p_resv) else $error("status reserved");
  property p_sticky; v1_q && rd_st |=> reg_rdata[1]; endproperty
  a_sticky: assert property (p_sticky) else $error("valid dropped");
  c_ready: cover property (rd_st ##1 reg_rdata[4]);
  c_both: cover property (rd_st ##1 reg_rdata[1:0] == 2'b11);
  c_lines: cover property (line_start == 2'b11 && frame_sync);
endmodule
bind frame_timestamp ts_checker u_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_sync(frame_sync),
  .line_start(line_start), .frame_start(frame_start));
`default_nettype wire

// >>> verif/link_rx_model.sv
// receive link model: frame sync, frame start, then two line starts
// assumes go is a one-cycle pulse; busy stays high for the frame
`timescale 1ns/1ps
`default_nettype none
module link_rx_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       pol,
  input  wire logic [8:0] gap,
  output logic            frame_sync = 1'b0,
  output logic      [1:0] frame_start = 2'b00,
  output logic      [1:0] line_start = 2'b00,
  output logic            busy = 1'b0
);
  // sync leaves idle for the whole frame: one active edge per frame
  always begin
    @(posedge clk);
    frame_sync <= go ? ~pol : pol;
    if (go) begin
      busy <= 1'b1;
      repeat (gap) @(posedge clk);
      frame_start <= 2'b11;
      @(posedge clk);
      frame_start <= 2'b00;
      repeat (2) begin
        repeat (gap - 1) @(posedge clk);
        line_start <= 2'b11;
        @(posedge clk);
        line_start <= 2'b00;
      end
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// bench for frame_timestamp: registers, capture, hold
// assumes the link model drives all frame and line events
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic go = 1'b0, pol = 1'b0, frame_sync, busy;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, r;
  logic [8:0] gap = 9'h004;
  logic [1:0] line_start, frame_start, en, ve = 2'b00;
  logic [15:0] es [2] = '{16'h0000, 16'h0000};
  int errors = 0, cmp_count = 0, seed = 53331, i, n;
  int cyc = 0, tg = 0, t0 = 0;
  always @(posedge clk) cyc <= cyc + 1;
  // gaps put each capture mid-tick, clear of the sync edge latency
  int gp [4] = '{4, 5, 9, 100};
  int pd [4] = '{ts_pkg::TICK0_CYC, ts_pkg::TICK1_CYC,
                 ts_pkg::TICK2_CYC, ts_pkg::TICK3_CYC};
  always #4 clk = ~clk;
  frame_timestamp u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_sync(frame_sync),
    .line_start(line_start), .frame_start(frame_start));
  link_rx_model u_link (.clk(clk), .go(go), .pol(pol), .gap(gap),
    .frame_sync(frame_sync), .frame_start(frame_start),
    .line_start(line_start), .busy(busy));
  function automatic logic [15:0] stamp_at(int cyc, int per);
    return 16'(cyc / per);
  endfunction
  task automatic acc(input logic w, input logic [7:0] a, v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, m, e, input string s);
    acc(1'b0, a, 8'h00);
    `CHK(s, e, d & m)
  endtask
  task automatic print_verdict;
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic frame(input logic [8:0] g);
    @(posedge clk);
    gap <= g;
    go <= 1'b1;
    tg = cyc;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (n = 0; busy && n < 2000; n++) #8;
    if (busy) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic stamps;
    for (int p = 0; p < 2; p++) begin
      rc(8'h2a + 8'(2 * p), 8'hff, es[p][15:8], "upper");
      rc(8'h2b + 8'(2 * p), 8'hff, es[p][7:0], "lower");
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 8'h25; i < 8'h2f; i++) rc(8'(i), 8'hff, 8'h00, "reset");
    repeat (6) begin
      r = 8'($random(seed));
      acc(1'b1, 8'h25, r);
      acc(1'b1, 8'h26, r);
      acc(1'b1, 8'h28, r);
      acc(1'b1, 8'h2a, r);
      rc(8'h25, 8'hff, r & ts_pkg::CFG_WMASK, "config");
      rc(8'h26, 8'hff, r & ts_pkg::CTL_WMASK, "control");
      rc(8'h28, 8'hff, r, "line");
      rc(8'h2a, 8'hff, 8'h00, "stamp");
    end
    acc(1'b1, 8'h27, 8'h00);
    acc(1'b1, 8'h28, 8'h02);
    for (i = 0; i < 4; i++) begin
      en = 2'(i % 3 + 1);
      pol <= i[0];
      acc(1'b1, 8'h25, {1'b0, i[0], i[1:0], i[1], 3'b000});
      acc(1'b1, 8'h26, {6'h00, en});
      frame(9'(gp[i]));
      for (n = 0; n < 2; n++)
        if (en[n]) es[n] = stamp_at(3 * gp[i], pd[i]);
      ve = ve | en;
      stamps();
      rc(8'h29, 8'h03, {6'h00, ve}, "valid");
      if (i[1]) rc(8'h29, 8'h10, 8'h10, "early ready");
    end
    acc(1'b1, 8'h26, 8'h13);
    rc(8'h29, 8'h10, 8'h00, "ready held");
    frame(9'h007);
    stamps();
    acc(1'b1, 8'h26, 8'h03);
    pol <= 1'b0;
    acc(1'b1, 8'h25, 8'h39);
    frame(9'h12c);
    es = '{2{stamp_at(300, ts_pkg::TICK3_CYC)}};
    stamps();
    rc(8'h29, 8'h13, 8'h13, "ready");
    // free run: the counter keeps running from the last sync restart
    t0 = tg;
    acc(1'b1, 8'h28, 8'h03);
    acc(1'b1, 8'h25, 8'h33);
    frame(9'h040);
    es = '{2{stamp_at(tg - t0 + 63, ts_pkg::TICK3_CYC)}};
    stamps();
    // only two lines reach target 3, so the port stays disarmed
    frame(9'h040);
    stamps();
    print_verdict();
  end
endmodule
`default_nettype wire
